// ---- rtl/spdc_core.sv ----
// Bus phase control, bus monitoring, selection match and DMA status
`timescale 1ns/100ps
`default_nettype none
module spdc_core
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Host register port
   input wire logic cs_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [2:0] addr,
   input wire logic [7:0] cpu_d_in,
   output logic [7:0] cpu_d_out,
   output logic cpu_d_oe,
   output logic irq,
   // DMA handshake
   output logic transfer_request_pin,
   input wire logic transfer_ack_pin_n,
   input wire logic end_of_process_pin_n,
   // Bus inputs, active low
   input wire logic bus_rst_n_in,
   input wire logic bus_bsy_n_in,
   input wire logic bus_req_n_in,
   input wire logic bus_ack_n_in,
   input wire logic bus_atn_n_in,
   input wire logic bus_msg_n_in,
   input wire logic bus_cd_n_in,
   input wire logic bus_io_n_in,
   input wire logic bus_sel_n_in,
   input wire logic bus_parity_bit_n_in,
   input wire logic [7:0] bus_db_n_in,
   // Bus open-drain outputs
   output logic [7:0] bus_ctl_n_out,
   output logic bus_bsy_oe,
   output logic bus_sel_oe,
   output logic bus_req_oe,
   output logic bus_ack_oe,
   output logic bus_atn_oe,
   output logic bus_msg_oe,
   output logic bus_cd_oe,
   output logic bus_io_oe,
   output logic [7:0] bus_db_n_out,
   output logic [7:0] bus_db_oe,
   output logic bus_parity_bit_n_out,
   output logic bus_parity_bit_oe
);
   spdc_mon_if mon ();
   logic wr_d_r, rd_d_r, req_d_r, selm_d_r, xrd_d_r;
   logic [7:0] mode_r, id_mask_r, odata_r, rd_data_r;
   logic [4:0] icr_r;
   logic [3:0] pc_r;
   logic last_pend_r, last_hs_r, last_sent_r;
   logic end_dma_r, drq_r, perr_r, berr_r, irq_r, block_r, dir_send_r;
   spdc_pkg::spdc_dma_e state_r, state_nxt;
   // ----------------------------------------------------------------
   // Pin monitor
   // ----------------------------------------------------------------
   spdc_bus_mon u_mon (
      .clock (clock),
      .arst_n (arst_n),
      .raw_n ({cs_n, read_strobe_n, write_strobe_n, ~addr, ~cpu_d_in,
         transfer_ack_pin_n, end_of_process_pin_n, bus_rst_n_in, bus_bsy_n_in,
         bus_req_n_in, bus_ack_n_in, bus_atn_n_in, bus_msg_n_in, bus_cd_n_in,
         bus_io_n_in, bus_sel_n_in, bus_parity_bit_n_in, bus_db_n_in}),
      .mon (mon)
   );
   // ----------------------------------------------------------------
   // Register access decode
   // ----------------------------------------------------------------
   wire wr_act = mon.cpu_cs & mon.cpu_wr;
   wire rd_act = mon.cpu_cs & mon.cpu_rd;
   wire wr_ev = wr_act & ~wr_d_r;
   wire rd_ev = rd_act & ~rd_d_r;
   wire [2:0] a = mon.cpu_addr;
   wire wr_data = wr_ev & (a == spdc_pkg::OFS_DATA);
   wire wr_icr = wr_ev & (a == spdc_pkg::OFS_INIT_CMD);
   wire wr_mode = wr_ev & (a == spdc_pkg::OFS_MODE);
   wire wr_pc = wr_ev & (a == spdc_pkg::OFS_PHASE_CTL);
   wire wr_id = wr_ev & (a == spdc_pkg::OFS_ID_MASK);
   wire wr_send = wr_ev & (a == spdc_pkg::OFS_SEND_START);
   wire wr_trecv = wr_ev & (a == spdc_pkg::OFS_TGT_RECV);
   wire wr_irecv = wr_ev & (a == spdc_pkg::OFS_INIT_RECV);
   wire clr7 = rd_ev & (a == spdc_pkg::OFS_ERR_CLR);
   // ----------------------------------------------------------------
   // Mode fields and live bus view
   // ----------------------------------------------------------------
   wire target = mode_r[spdc_pkg::MODE_TARGET];
   wire dma_en = mode_r[spdc_pkg::MODE_DMA_EN];
   wire par_chk = mode_r[spdc_pkg::MODE_PAR_CHK];
   wire arb = mode_r[spdc_pkg::MODE_ARB];
   wire [2:0] phase_live = {mon.b_msg, mon.b_cd, mon.b_io};
   wire phase_match = (pc_r[2:0] == phase_live);
   wire [7:0] live_view = {mon.b_rst, mon.b_bsy, mon.b_req, mon.b_msg, mon.b_cd,
      mon.b_io, mon.b_sel, mon.b_par};
   wire [7:0] status = {end_dma_r, drq_r, perr_r, irq_r, phase_match, berr_r,
      mon.b_atn, mon.b_ack};
   // ----------------------------------------------------------------
   // Events
   // ----------------------------------------------------------------
   wire running = (state_r == spdc_pkg::SPDC_SEND) | (state_r == spdc_pkg::SPDC_RECV);
   wire any_strobe = mon.cpu_rd | mon.cpu_wr;
   wire xfer_rd = mon.transfer_ack_pin & mon.cpu_rd;
   wire xfer_wr = mon.transfer_ack_pin & mon.cpu_wr;
   wire eop_valid = mon.transfer_ack_pin & mon.eop & any_strobe;
   wire sel_match = mon.b_sel & ~mon.b_bsy & (|(mon.b_db & id_mask_r));
   wire sel_ev = sel_match & ~selm_d_r;
   wire req_ev = mon.b_req & ~req_d_r;
   wire phm_ev = ~target & dma_en & req_ev & ~phase_match;
   wire recv_ev = xfer_rd & ~xrd_d_r & (state_r == spdc_pkg::SPDC_RECV);
   wire perr_set = par_chk & ~mon.par_ok & (sel_ev | recv_ev);
   wire berr_set = mode_r[spdc_pkg::MODE_BSY_MON] & mon.bsy_lost & ~berr_r;
   wire irq_set = sel_ev | phm_ev | berr_set
      | (mode_r[spdc_pkg::MODE_EOP_INT] & eop_valid)
      | (mode_r[spdc_pkg::MODE_PAR_INT] & perr_set);
   wire start_send = wr_send & dma_en;
   wire start_trecv = wr_trecv & dma_en & target;
   wire start_irecv = wr_irecv & dma_en & ~target;
   wire start_any = start_send | start_trecv | start_irecv;
   // ----------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------
   wire [7:0] mode_base = wr_mode ? mon.cpu_wdata : mode_r;
   wire [7:0] mode_nxt = {mode_base[7:2], mode_base[1] & ~berr_set, mode_base[0]};
   wire irq_nxt = irq_set | (irq_r & ~clr7);
   wire berr_nxt = berr_set | (berr_r & ~clr7);
   wire perr_nxt = perr_set | (perr_r & ~clr7);
   wire end_dma_nxt = dma_en & (end_dma_r | eop_valid);
   wire drq_ack = mon.transfer_ack_pin & (dir_send_r ? mon.cpu_wr : mon.cpu_rd);
   wire drq_raise = running & (block_r ? ~any_strobe : ~mon.transfer_ack_pin);
   wire drq_nxt = ~dma_en ? 1'b0 : drq_ack ? 1'b0 : (drq_raise | drq_r);
   wire last_clr = ~dma_en | start_any;
   wire last_pend_nxt = ~last_clr & (last_pend_r
      | (eop_valid & (state_r == spdc_pkg::SPDC_SEND)));
   wire last_hs_nxt = ~last_clr & (last_hs_r | (last_pend_r & mon.b_req & mon.b_ack));
   wire last_sent_nxt = ~last_clr & (last_sent_r
      | (last_hs_r & ~mon.b_req & ~mon.b_ack));
   wire [7:0] rd_mux =
      (a == spdc_pkg::OFS_DATA) ? mon.b_db :
      (a == spdc_pkg::OFS_INIT_CMD) ? {3'h0, icr_r} :
      (a == spdc_pkg::OFS_MODE) ? mode_r :
      (a == spdc_pkg::OFS_PHASE_CTL) ? {last_sent_r, 3'h0, pc_r} :
      (a == spdc_pkg::OFS_LIVE_VIEW) ? live_view :
      (a == spdc_pkg::OFS_STATUS) ? status : 8'h00;
   // ----------------------------------------------------------------
   // DMA sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         spdc_pkg::SPDC_IDLE,
         spdc_pkg::SPDC_HALT:
         begin
            if (start_send)
               state_nxt = spdc_pkg::SPDC_SEND;
            else if (start_trecv | start_irecv)
               state_nxt = spdc_pkg::SPDC_RECV;
         end
         spdc_pkg::SPDC_SEND,
         spdc_pkg::SPDC_RECV:
         begin
            if (eop_valid | phm_ev)
               state_nxt = spdc_pkg::SPDC_HALT;
         end
      endcase
      if (!dma_en)
         state_nxt = spdc_pkg::SPDC_IDLE;
   end
   // ----------------------------------------------------------------
   // Edge history and strobes
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_d_r <= 1'b0;
         rd_d_r <= 1'b0;
         req_d_r <= 1'b0;
         selm_d_r <= 1'b0;
         xrd_d_r <= 1'b0;
      end
      else
      begin
         wr_d_r <= wr_act;
         rd_d_r <= rd_act;
         req_d_r <= mon.b_req;
         selm_d_r <= sel_match;
         xrd_d_r <= xfer_rd;
      end
   end
   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_r <= spdc_pkg::MODE_RST;
         icr_r <= spdc_pkg::ICR_RST;
         pc_r <= spdc_pkg::PC_RST;
         id_mask_r <= spdc_pkg::ID_RST;
         odata_r <= spdc_pkg::ODATA_RST;
      end
      else
      begin
         mode_r <= mode_nxt;
         if (wr_icr)
            icr_r <= mon.cpu_wdata[4:0];
         if (wr_pc)
            pc_r <= mon.cpu_wdata[3:0];
         if (wr_id)
            id_mask_r <= mon.cpu_wdata;
         if (wr_data)
            odata_r <= mon.cpu_wdata;
      end
   end
   // ----------------------------------------------------------------
   // Status and DMA state
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= spdc_pkg::SPDC_IDLE;
         block_r <= 1'b0;
         dir_send_r <= 1'b0;
         irq_r <= 1'b0;
         berr_r <= 1'b0;
         perr_r <= 1'b0;
         end_dma_r <= 1'b0;
         drq_r <= 1'b0;
         last_pend_r <= 1'b0;
         last_hs_r <= 1'b0;
         last_sent_r <= 1'b0;
         rd_data_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         if (start_any)
         begin
            block_r <= mode_r[spdc_pkg::MODE_BLOCK];
            dir_send_r <= start_send;
         end
         irq_r <= irq_nxt;
         berr_r <= berr_nxt;
         perr_r <= perr_nxt;
         end_dma_r <= end_dma_nxt;
         drq_r <= drq_nxt;
         last_pend_r <= last_pend_nxt;
         last_hs_r <= last_hs_nxt;
         last_sent_r <= last_sent_nxt;
         rd_data_r <= rd_mux;
      end
   end
   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   wire out_on = ~berr_r;
   wire db_drive = out_on & ~arb & icr_r[spdc_pkg::ICR_DBUS]
      & (target | (phase_match & ~mon.b_io));
   assign cpu_d_out = rd_data_r;
   assign cpu_d_oe = rd_act;
   assign irq = irq_r;
   assign transfer_request_pin = drq_r;
   assign bus_ctl_n_out = 8'h00;
   assign bus_bsy_oe = out_on & icr_r[spdc_pkg::ICR_BSY];
   assign bus_sel_oe = out_on & icr_r[spdc_pkg::ICR_SEL];
   assign bus_req_oe = out_on & target & pc_r[spdc_pkg::PC_REQ];
   assign bus_msg_oe = out_on & target & pc_r[2];
   assign bus_cd_oe = out_on & target & pc_r[1];
   assign bus_io_oe = out_on & target & pc_r[0];
   assign bus_ack_oe = out_on & ~target & icr_r[spdc_pkg::ICR_ACK];
   assign bus_atn_oe = out_on & ~target & icr_r[spdc_pkg::ICR_ATN];
   assign bus_db_n_out = 8'h00;
   assign bus_db_oe = {8{db_drive}} & odata_r;
   assign bus_parity_bit_n_out = 1'b0;
   assign bus_parity_bit_oe = db_drive & ~(^odata_r);
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence s_sel_seen;
      mon.b_sel && !mon.b_bsy ##0 (|(mon.b_db & id_mask_r)) && !selm_d_r;
   endsequence
   sequence s_send_ack;
      drq_r && dir_send_r ##0 mon.transfer_ack_pin && mon.cpu_wr;
   endsequence
   a_clear_drops_irq: assert property (clr7 && !irq_set |=> !irq && !berr_r)
      else $error("offset 7 read did not clear interrupt");
   a_busy_err_quiet: assert property (berr_r |-> !bus_req_oe && !bus_bsy_oe
      && bus_db_oe == 8'h00)
      else $error("bus driven while busy error set");
   a_busy_kills_dma: assert property (berr_set |=> !dma_en && berr_r)
      else $error("busy error left DMA enabled");
   a_req_target_only: assert property (bus_req_oe |-> target && pc_r[3])
      else $error("REQ driven outside responder role");
   a_io_target_only: assert property (bus_io_oe || bus_cd_oe |-> target)
      else $error("phase line driven outside responder role");
   a_phase_irq: assert property (phm_ev |=> irq_r ##0 state_r != spdc_pkg::SPDC_SEND)
      else $error("phase mismatch did not interrupt");
   a_sel_irq: assert property (s_sel_seen |=> irq_r)
      else $error("selection match did not interrupt");
   a_drq_ack_clear: assert property (s_send_ack |=> !drq_r)
      else $error("request stayed after send acknowledge");
   a_end_dma_clear: assert property (!dma_en |=> !end_dma_r && !drq_r)
      else $error("DMA status kept with DMA disabled");
   a_recv_start: assert property (start_trecv |=> state_r == spdc_pkg::SPDC_RECV)
      else $error("responder receive did not start");
   a_par_gated: assert property (!par_chk && !perr_r |=> !perr_r)
      else $error("parity error latched with checking off");
endmodule : spdc_core
`default_nettype wire

// ---- rtl/spdc_pkg.sv ----
// Constants and types shared by the bus phase and DMA control block
package spdc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUSY_SETTLE_NS = 400;
   localparam int BUSY_SETTLE_CYC = (BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_INIT_CMD = 3'h1;
   localparam logic [2:0] OFS_MODE = 3'h2;
   localparam logic [2:0] OFS_PHASE_CTL = 3'h3;
   localparam logic [2:0] OFS_LIVE_VIEW = 3'h4;
   localparam logic [2:0] OFS_ID_MASK = 3'h4;
   localparam logic [2:0] OFS_STATUS = 3'h5;
   localparam logic [2:0] OFS_SEND_START = 3'h5;
   localparam logic [2:0] OFS_TGT_RECV = 3'h6;
   localparam logic [2:0] OFS_ERR_CLR = 3'h7;
   localparam logic [2:0] OFS_INIT_RECV = 3'h7;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MODE_BLOCK = 7;
   localparam int MODE_TARGET = 6;
   localparam int MODE_PAR_CHK = 5;
   localparam int MODE_PAR_INT = 4;
   localparam int MODE_EOP_INT = 3;
   localparam int MODE_BSY_MON = 2;
   localparam int MODE_DMA_EN = 1;
   localparam int MODE_ARB = 0;
   localparam int ICR_ACK = 4;
   localparam int ICR_BSY = 3;
   localparam int ICR_SEL = 2;
   localparam int ICR_ATN = 1;
   localparam int ICR_DBUS = 0;
   localparam int PC_REQ = 3;
   // ----------------------------------------------------------------
   // Reset values and pin vector width
   // ----------------------------------------------------------------
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [4:0] ICR_RST = 5'h00;
   localparam logic [3:0] PC_RST = 4'h0;
   localparam logic [7:0] ID_RST = 8'h00;
   localparam logic [7:0] ODATA_RST = 8'h00;
   localparam int PIN_W = 34;
   typedef enum logic [1:0] {
      SPDC_IDLE = 2'b00,
      SPDC_SEND = 2'b01,
      SPDC_RECV = 2'b10,
      SPDC_HALT = 2'b11
   } spdc_dma_e;
endpackage : spdc_pkg

// ---- rtl/spdc_mon_if.sv ----
// Synchronised pin view passed from the monitor to the control core
`timescale 1ns/100ps
`default_nettype none
interface spdc_mon_if;
   logic cpu_cs, cpu_rd, cpu_wr;
   logic [2:0] cpu_addr;
   logic [7:0] cpu_wdata;
   logic transfer_ack_pin, eop;
   logic b_rst, b_bsy, b_req, b_ack, b_atn, b_msg, b_cd, b_io, b_sel, b_par;
   logic [7:0] b_db;
   logic par_ok, bsy_lost;
   modport mon (output cpu_cs, cpu_rd, cpu_wr, cpu_addr, cpu_wdata, transfer_ack_pin, eop,
      b_rst, b_bsy, b_req, b_ack, b_atn, b_msg, b_cd, b_io, b_sel, b_par, b_db,
      par_ok, bsy_lost);
   modport core (input cpu_cs, cpu_rd, cpu_wr, cpu_addr, cpu_wdata, transfer_ack_pin, eop,
      b_rst, b_bsy, b_req, b_ack, b_atn, b_msg, b_cd, b_io, b_sel, b_par, b_db,
      par_ok, bsy_lost);
endinterface : spdc_mon_if
`default_nettype wire

// ---- rtl/spdc_bus_mon.sv ----
// Pin synchroniser, parity checker and busy-loss timer
`timescale 1ns/100ps
`default_nettype none
module spdc_bus_mon
#(
   parameter int SETTLE_CYC = spdc_pkg::BUSY_SETTLE_CYC
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Raw active-low pins
   input wire logic [spdc_pkg::PIN_W-1:0] raw_n,
   // Synchronised view
   spdc_mon_if.mon mon
);
   localparam int CW = $clog2(SETTLE_CYC + 1);
   localparam logic [CW-1:0] LIMIT = CW'(SETTLE_CYC);
   logic [spdc_pkg::PIN_W-1:0] meta_r, sync_r;
   logic [CW-1:0] idle_cnt_r;
   // ----------------------------------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_r <= '1;
         sync_r <= '1;
      end
      else
      begin
         meta_r <= raw_n;
         sync_r <= meta_r;
      end
   end
   wire [spdc_pkg::PIN_W-1:0] act = ~sync_r;
   assign mon.cpu_cs = act[33];
   assign mon.cpu_rd = act[32];
   assign mon.cpu_wr = act[31];
   // Address and data enter inverted so that reset reads as zero
   assign mon.cpu_addr = act[30:28];
   assign mon.cpu_wdata = act[27:20];
   assign mon.transfer_ack_pin = act[19];
   assign mon.eop = act[18];
   assign mon.b_rst = act[17];
   assign mon.b_bsy = act[16];
   assign mon.b_req = act[15];
   assign mon.b_ack = act[14];
   assign mon.b_atn = act[13];
   assign mon.b_msg = act[12];
   assign mon.b_cd = act[11];
   assign mon.b_io = act[10];
   assign mon.b_sel = act[9];
   assign mon.b_par = act[8];
   assign mon.b_db = act[7:0];
   // Odd parity over data plus parity bit
   assign mon.par_ok = ^act[8:0];
   // ----------------------------------------------------------------
   // Busy-loss timer
   // ----------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         idle_cnt_r <= '0;
      else if (act[16])
         idle_cnt_r <= '0;
      else if (idle_cnt_r != LIMIT)
         idle_cnt_r <= idle_cnt_r + CW'(1);
   end
   assign mon.bsy_lost = (idle_cnt_r == LIMIT);
   a_busy_lost_wait: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(mon.bsy_lost) |-> $past(idle_cnt_r) == LIMIT - CW'(1) && !mon.b_bsy)
      else $error("busy loss flagged before the settle time");
endmodule : spdc_bus_mon
`default_nettype wire

// ---- testbench/spdc_far_dev.sv ----
// Far-side bus device model with open-drain wiring of every line
`timescale 1ns/100ps
`default_nettype none
module spdc_far_dev
(
   // Bench commands: rst,bsy,req,msg,cd,io,sel asserted high
   input wire logic [6:0] dev_asrt,
   input wire logic [7:0] dev_db,
   // Block drives
   input wire logic bus_bsy_oe, bus_sel_oe, bus_req_oe, bus_ack_oe, bus_atn_oe,
   input wire logic bus_msg_oe, bus_cd_oe, bus_io_oe, bus_parity_bit_oe,
   input wire logic [7:0] bus_db_oe,
   // Resolved lines, pulled up when released
   output logic bus_rst_n_in, bus_bsy_n_in, bus_req_n_in, bus_ack_n_in, bus_atn_n_in,
   output logic bus_msg_n_in, bus_cd_n_in, bus_io_n_in, bus_sel_n_in, bus_parity_bit_n_in,
   output logic [7:0] bus_db_n_in
);
   assign bus_rst_n_in = ~dev_asrt[6];
   assign bus_bsy_n_in = ~(dev_asrt[5] | bus_bsy_oe);
   assign bus_req_n_in = ~(dev_asrt[4] | bus_req_oe);
   assign bus_msg_n_in = ~(dev_asrt[3] | bus_msg_oe);
   assign bus_cd_n_in = ~(dev_asrt[2] | bus_cd_oe);
   assign bus_io_n_in = ~(dev_asrt[1] | bus_io_oe);
   assign bus_sel_n_in = ~(dev_asrt[0] | bus_sel_oe);
   assign bus_ack_n_in = ~bus_ack_oe;
   assign bus_atn_n_in = ~bus_atn_oe;
   assign bus_db_n_in = ~(dev_db | bus_db_oe);
   // Odd parity over the data the device asserts
   assign bus_parity_bit_n_in = ~((~^dev_db) | bus_parity_bit_oe);
endmodule : spdc_far_dev
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the phase and DMA control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic clock, arst_n, cs_n, read_strobe_n, write_strobe_n, cpu_d_oe, irq;
   logic transfer_request_pin, transfer_ack_pin_n, end_of_process_pin_n;
   logic [2:0] addr;
   logic [7:0] cpu_d_in, cpu_d_out, bus_ctl_n_out, bus_db_n_out, bus_db_oe, bus_db_n_in;
   logic [7:0] dev_db, q, d0;
   logic bus_rst_n_in, bus_bsy_n_in, bus_req_n_in, bus_ack_n_in, bus_atn_n_in, bus_msg_n_in;
   logic bus_cd_n_in, bus_io_n_in, bus_sel_n_in, bus_parity_bit_n_in, bus_parity_bit_n_out;
   logic bus_bsy_oe, bus_sel_oe, bus_req_oe, bus_ack_oe, bus_atn_oe, bus_msg_oe, bus_cd_oe;
   logic bus_io_oe, bus_parity_bit_oe;
   logic [6:0] dev_asrt;
   int n_errors = 0, n_tests = 0, seed, k, cyc = 0;
   spdc_core dut_u (.*);
   spdc_far_dev far_u (.*);
   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task automatic report_and_stop();
      if (n_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_errors = n_errors + 1;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Host register cycle; read data taken while the strobe is still low
   task automatic acc(input logic rd, input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      cs_n <= 0; addr <= a; cpu_d_in <= d;
      if (rd) read_strobe_n <= 0; else write_strobe_n <= 0;
      repeat (5) @(posedge clock);
      q = cpu_d_out;
      if (rd)
         chk("d_oe", 8'h01, {7'h0, cpu_d_oe});
      cs_n <= 1; read_strobe_n <= 1; write_strobe_n <= 1;
      repeat (4) @(posedge clock);
   endtask : acc
   // DMA acknowledge with write strobe, optionally ending the transfer
   task automatic transfer_ack_pin(input logic e);
      @(posedge clock);
      transfer_ack_pin_n <= 0; write_strobe_n <= 0; end_of_process_pin_n <= ~e;
      repeat (5) @(posedge clock);
      chk("drq_acked", 8'h00, {7'h0, transfer_request_pin});
      transfer_ack_pin_n <= 1; write_strobe_n <= 1; end_of_process_pin_n <= 1;
      repeat (5) @(posedge clock);
   endtask : transfer_ack_pin
   initial
   begin
      seed = 3872;
      arst_n = 0; cs_n = 1; read_strobe_n = 1; write_strobe_n = 1; addr = 3'h0;
      cpu_d_in = 8'h00; transfer_ack_pin_n = 1; end_of_process_pin_n = 1;
      dev_asrt = 7'h00; dev_db = 8'h00;
      repeat (6) @(posedge clock);
      arst_n <= 1;
      for (k = 0; k < 4; k++)
      begin
         @(posedge clock);
         dev_asrt <= 7'($random(seed)) & 7'h3f; dev_db <= 8'($random(seed));
         acc(1, 3'h4, 8'h00);
         chk("live_view", {dev_asrt, ~^dev_db}, q);
      end
      dev_asrt <= 7'h00;
      acc(0, 3'h2, 8'h40);
      for (k = 0; k < 8; k++)
      begin
         acc(0, 3'h3, 8'h08 | 8'(k));
         chk("phase_oe", 8'h08 | 8'(k), {4'h0, bus_req_oe, bus_msg_oe, bus_cd_oe, bus_io_oe});
         acc(1, 3'h3, 8'h00);
         chk("phase_rd", 8'h08 | 8'(k), q);
      end
      d0 = 8'($random(seed));
      acc(0, 3'h0, d0);
      acc(0, 3'h1, 8'h01);
      chk("db_drive", d0, bus_db_oe);
      chk("par_drive", {7'h0, ~^d0}, {7'h0, bus_parity_bit_oe});
      acc(0, 3'h2, 8'h41);
      chk("arb_no_db", 8'h00, bus_db_oe);
      acc(0, 3'h1, 8'h00);
      acc(0, 3'h2, 8'h00);
      chk("no_drive", 8'h00, {4'h0, bus_req_oe, bus_msg_oe, bus_cd_oe, bus_io_oe});
      acc(0, 3'h1, 8'h1e);
      chk("init_oe", 8'h0f, {4'h0, bus_ack_oe, bus_bsy_oe, bus_sel_oe, bus_atn_oe});
      acc(0, 3'h1, 8'h00);
      for (k = 0; k < 8; k++)
      begin
         @(posedge clock);
         dev_asrt <= {3'h0, 3'(k), 1'b0};
         acc(1, 3'h5, 8'h00);
         chk("phase_match", (k == 7) ? 8'h08 : 8'h00, q & 8'h08);
      end
      k = {$random(seed)} % 8;
      acc(0, 3'h4, 8'h01 << k);
      dev_asrt <= 7'h01; dev_db <= 8'h01 << k;
      repeat (6) @(posedge clock);
      chk("sel_irq", 8'h01, {7'h0, irq});
      acc(1, 3'h5, 8'h00);
      chk("irq_bit", 8'h10, q & 8'h10);
      dev_asrt <= 7'h00; dev_db <= 8'h00;
      acc(1, 3'h7, 8'h00);
      chk("irq_clr", 8'h00, {7'h0, irq});
      acc(0, 3'h5, 8'h00);
      chk("drq_noen", 8'h00, {7'h0, transfer_request_pin});
      acc(0, 3'h2, 8'h02);
      acc(0, 3'h6, 8'hff);
      chk("drq_role", 8'h00, {7'h0, transfer_request_pin});
      acc(0, 3'h5, 8'($random(seed)));
      chk("drq_send", 8'h01, {7'h0, transfer_request_pin});
      acc(1, 3'h5, 8'h00);
      chk("drq_bit", 8'h40, q & 8'h40);
      transfer_ack_pin(1'b0);
      chk("drq_again", 8'h01, {7'h0, transfer_request_pin});
      transfer_ack_pin(1'b1);
      acc(1, 3'h5, 8'h00);
      chk("end_dma", 8'h80, q & 8'hc0);
      acc(0, 3'h2, 8'h00);
      acc(1, 3'h5, 8'h00);
      chk("dma_off", 8'h00, q & 8'hc0);
      acc(0, 3'h2, 8'h02);
      acc(0, 3'h3, 8'h00);
      dev_asrt <= 7'h18;
      repeat (6) @(posedge clock);
      chk("mismatch_irq", 8'h01, {7'h0, irq});
      dev_asrt <= 7'h20;
      acc(1, 3'h7, 8'h00);
      chk("irq_clr2", 8'h00, {7'h0, irq});
      acc(0, 3'h2, 8'h06);
      dev_asrt <= 7'h00;
      repeat (60) @(posedge clock);
      acc(1, 3'h5, 8'h00);
      chk("busy_err", 8'h04, q & 8'h04);
      acc(1, 3'h2, 8'h00);
      chk("mode_dma_off", 8'h04, q);
      acc(0, 3'h2, 8'h00);
      acc(1, 3'h7, 8'h00);
      acc(1, 3'h5, 8'h00);
      chk("busy_clr", 8'h00, q & 8'h04);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
